// >>> dv/errwin_core_model.sv
// Core-side model issuing window register accesses
`timescale 1ns/10ps
module errwin_core_model
  import errwin_pkg::*;
(
  input  wire logic                clk,
  output logic                     req_valid,
  output logic                     req_write,
  output logic [2:0]               req_op1,
  output logic [3:0]               req_crn,
  output logic [3:0]               req_crm,
  output logic [2:0]               req_op2,
  output logic [31:0]              req_wdata,
  input  wire logic                rsp_valid,
  input  wire logic [31:0]         rsp_rdata,
  input  wire errwin_pkg::result_e rsp_result
);
  logic        got_vld;
  logic [31:0] got_data;
  result_e     got_res;

  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_op1   = 3'h0;
    req_crn   = 4'h5;
    req_crm   = 4'h5;
    req_op2   = 3'h0;
    req_wdata = 32'h0;
  end

  // One access: drive after an edge, hold to the taking edge, take answer
  task automatic acc(input logic w, input logic [3:0] crm,
                     input logic [2:0] op2, input logic [31:0] d);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = w;
    req_crm   = crm;
    req_op2   = op2;
    req_wdata = d;
    @(posedge clk);
    #1;
    got_vld   = rsp_valid;
    got_data  = rsp_rdata;
    got_res   = rsp_result;
    req_valid = 1'b0;
    req_wdata = ~d;
  endtask

  // Write then read of the same low misc window on back-to-back edges
  task automatic wr_rd(input logic [31:0] d);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_crm   = 4'h5;
    req_op2   = 3'h0;
    req_wdata = d;
    @(posedge clk);
    #1;
    req_write = 1'b0;
    req_wdata = ~d;
    @(posedge clk);
    #1;
    got_vld   = rsp_valid;
    got_data  = rsp_rdata;
    got_res   = rsp_result;
    req_valid = 1'b0;
  endtask
endmodule

// >>> dv/tb_selected_error_record_window.sv
// Testbench for the selected error record window block
`timescale 1ns/10ps
module tb_selected_error_record_window;
  import errwin_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [1:0] priv;
  logic ns, mon, ext, e2p, e2w, e3p, e3w;
  logic the, th5, th32e, th325, tme, tm32e;
  logic [1:0] sel;
  logic [2:0] cnt;
  logic vld, wr, rv, hit;
  logic [2:0] op1, op2;
  logic [3:0] crn, crm;
  logic [31:0] wd, rd;
  result_e res;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [3:0] wc [5] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h4};
  logic [2:0] wo [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2};

  always #5 CLK = ~CLK;

  errwin_core_model core (.clk(CLK), .req_valid(vld), .req_write(wr),
    .req_op1(op1), .req_crn(crn), .req_crm(crm), .req_op2(op2),
    .req_wdata(wd), .rsp_valid(rv), .rsp_rdata(rd), .rsp_result(res));

  errwin_top #(.NUM_RECORDS(4), .IDX_W(2)) uut (.CLK(CLK), .RST_N(RST_N),
    .REQ_VALID(vld), .REQ_WRITE(wr), .REQ_OP1(op1), .REQ_CRN(crn),
    .REQ_CRM(crm), .REQ_OP2(op2), .REQ_WDATA(wd), .PRIV_LEVEL(priv),
    .NONSECURE(ns), .MONITOR_MODE(mon), .ERR_EXT_PRESENT(ext),
    .EL2_PRESENT(e2p), .EL2_IS_64(e2w), .EL3_PRESENT(e3p),
    .EL3_IS_64(e3w), .HYP_ERROR_TRAP_BIT(the), .HYP_CRN5_TRAP_BIT(th5),
    .HYP32_ERROR_TRAP_BIT(th32e), .HYP32_CRN5_TRAP_BIT(th325),
    .MONITOR_ERROR_TRAP_BIT(tme), .MONITOR32_ERROR_TRAP_BIT(tm32e),
    .RECORD_SELECTOR(sel), .RECORD_COUNT(cnt), .RSP_VALID(rv),
    .RSP_RDATA(rd), .RSP_RESULT(res), .RSP_HIT(hit));

  task final_report;
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chkd(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t data %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkr(input result_e g, input result_e e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t result %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic ac(input logic w, input int k, input logic [31:0] d,
                    input result_e er, input logic [31:0] ed);
    core.acc(w, wc[k], wo[k], d);
    chkd({31'h0, core.got_vld}, 32'h1);
    chkd({31'h0, hit}, 32'h1);
    chkr(core.got_res, er);
    chkd(core.got_data, ed);
  endtask

  task base;
    {priv, ns, mon, ext, e2p, e2w, e3p, e3w} = {2'h1, 7'h1f};
    {the, th5, th32e, th325, tme, tm32e} = 6'h0;
    sel = 2'h1;
    cnt = 3'h4;
  endtask

  task t_windows;
    base();
    for (int i = 0; i < 5; i++) ac(1, i, 32'ha5000000 + 32'(i), RES_OK, 0);
    for (int i = 0; i < 5; i++) ac(0, i, 0, RES_OK, 32'ha5000000 + 32'(i));
    ac(1, 0, 32'h12345678, RES_OK, 0);
    ac(0, 1, 0, RES_OK, 32'ha5000001);
    ac(0, 0, 0, RES_OK, 32'h12345678);
    ns = 1'b1;
    ac(0, 4, 0, RES_OK, 32'ha5000004);
    sel = 2'h2;
    ac(0, 0, 0, RES_OK, 0);
    core.wr_rd(32'h0badf00d);
    chkd(core.got_data, 32'h0badf00d);
  endtask

  task t_undef;
    base();
    priv = 2'h0;
    ac(1, 2, 32'hdeadbeef, RES_UNDEF, 0);
    {the, tme, tm32e} = 3'h7;
    ac(0, 2, 0, RES_UNDEF, 0);
    base();
    ext = 1'b0;
    {ns, the} = 2'h3;
    ac(1, 2, 32'hdeadbeef, RES_UNDEF, 0);
    base();
    ac(0, 2, 0, RES_OK, 32'ha5000002);
  endtask

  task t_range;
    base();
    {sel, cnt} = {2'h3, 3'h3};
    ac(1, 3, 32'hcafef00d, RES_OK, 0);
    ac(0, 3, 0, RES_OK, 0);
    cnt = 3'h4;
    ac(0, 3, 0, RES_OK, 0);
    {sel, cnt} = {2'h0, 3'h0};
    ac(0, 3, 0, RES_OK, 0);
    {sel, cnt} = {2'h1, 3'h1};
    ac(0, 0, 0, RES_OK, 0);
    cnt = 3'h4;
    core.acc(1, 4'h4, 3'h7, 32'h1);
    chkd({31'h0, hit}, 32'h0);
    chkr(core.got_res, RES_OK);
    ac(0, 0, 0, RES_OK, 32'h12345678);
  endtask

  task t_traps;
    base();
    ns = 1'b1;
    the = 1'b1;
    tme = 1'b1;
    ac(1, 0, 32'h1, RES_TRAP_EL2, 0);
    {the, th5} = 2'h1;
    ac(0, 0, 0, RES_TRAP_EL2, 0);
    {e2w, th5, th32e} = 3'h1;
    ac(0, 1, 0, RES_HYP_TRAP, 0);
    {th32e, th325} = 2'h1;
    ac(0, 1, 0, RES_HYP_TRAP, 0);
    ns = 1'b0;
    ac(0, 0, 0, RES_TRAP_EL3, 0);
    priv = 2'h2;
    ac(0, 0, 0, RES_TRAP_EL3, 0);
    {e3w, tme, tm32e} = 3'h1;
    ac(0, 0, 0, RES_MON_TRAP, 0);
    {priv, mon} = 3'h7;
    ac(0, 0, 0, RES_OK, 32'h12345678);
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    base();
    repeat (3) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    t_windows();
    t_undef();
    t_range();
    t_traps();
    final_report();
  end
endmodule

// >>> rtl/errwin_pkg.sv
// Constants and types for the selected error record window block
// Operation
// RULE1: Encoding 0,c5,c5,0 reads/writes bits 31:0 of misc register a.
// RULE2: Encoding 0,c5,c5,1 reads/writes bits 63:32 of misc register a.
// RULE3: Encoding 0,c5,c5,4 reads/writes bits 31:0 of misc register b.
// RULE4: Encoding 0,c5,c5,5 reads/writes bits 63:32 of misc register b.
// RULE5: Encoding 0,c5,c4,2 reads/writes bits 31:0 of the status register.
// RULE6: Any window access at level 0 is undefined.
// RULE7: Out-of-range selector: one fixed behaviour; here reads zero, writes ignored.
// RULE8: 64-bit level 2 error trap bit traps non-secure level 1 accesses.
// RULE9: 64-bit level 2 CRn 5 trap bit traps non-secure level 1 accesses.
// RULE10: 32-bit level 2 error trap bit gives hyp trap at non-secure level 1.
// RULE11: 32-bit level 2 CRn 5 trap bit gives hyp trap at non-secure level 1.
// RULE12: 64-bit level 3 error trap bit traps levels 2 and 1 to level 3.
// RULE13: 32-bit level 3 error trap bit traps all modes except monitor; here level 3 accesses are not trapped either, monitor mode or not.
// RULE14: Only the highest priority undefined or trap outcome is reported.
// RULE15: One shared instance of each window for both security states.
// RULE16: Without the error extension every window access is undefined.
// RULE17: Records hold 64-bit status and misc; status at 0x010 plus 64 times n.
// RULE18: A window write changes only its addressed 32-bit half.
package errwin_pkg;

  localparam logic [2:0] OP1_WIN    = 3'h0;
  localparam logic [3:0] CRN_WIN    = 4'h5;
  localparam logic [3:0] CRM_MISC   = 4'h5;
  localparam logic [3:0] CRM_STATUS = 4'h4;
  localparam logic [2:0] OP2_M0_LO  = 3'h0;
  localparam logic [2:0] OP2_M0_HI  = 3'h1;
  localparam logic [2:0] OP2_M1_LO  = 3'h4;
  localparam logic [2:0] OP2_M1_HI  = 3'h5;
  localparam logic [2:0] OP2_ST_LO  = 3'h2;

  localparam logic [11:0] MM_STATUS_BASE = 12'h010;
  localparam logic [11:0] MM_MISC0_BASE  = 12'h020;
  localparam logic [11:0] MM_MISC1_BASE  = 12'h028;
  localparam int          MM_RECORD_STEP = 64;

  localparam logic [63:0] RECORD_RESET = 64'h0;

  typedef enum logic [1:0] {
    FIELD_STATUS = 2'h0,
    FIELD_MISC0  = 2'h1,
    FIELD_MISC1  = 2'h2
  } field_e;

  typedef enum logic [2:0] {
    RES_OK       = 3'h0,
    RES_UNDEF    = 3'h1,
    RES_TRAP_EL2 = 3'h2,
    RES_HYP_TRAP = 3'h3,
    RES_TRAP_EL3 = 3'h4,
    RES_MON_TRAP = 3'h5
  } result_e;

endpackage

// >>> rtl/errwin_record_store.sv
// Flip-flop store of 64-bit error records with half-word write
`timescale 1ns/10ps
module errwin_record_store
  import errwin_pkg::*;
#(
  parameter int NUM_RECORDS = 4,
  parameter int IDX_W       = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [IDX_W-1:0] idx,
  input  wire errwin_pkg::field_e field,
  input  wire logic             hi_half,
  input  wire logic             wr_en,
  input  wire logic [31:0]      wr_data,
  output logic      [31:0]      rd_data
);

  import errwin_pkg::*;

  logic [63:0] status_q [NUM_RECORDS];
  logic [63:0] misc0_q  [NUM_RECORDS];
  logic [63:0] misc1_q  [NUM_RECORDS];
  logic [63:0] sel_word;

  assign sel_word = (field == FIELD_STATUS) ? status_q[idx] :
                    (field == FIELD_MISC0)  ? misc0_q[idx]  : misc1_q[idx];
  assign rd_data  = hi_half ? sel_word[63:32] : sel_word[31:0];

  function automatic logic [63:0] merge(input logic [63:0] old,
                                        input logic        hi,
                                        input logic [31:0] d);
    merge = hi ? {d, old[31:0]} : {old[63:32], d}; // RULE18
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_RECORDS; i++) begin
        status_q[i] <= RECORD_RESET; // RULE17
        misc0_q[i]  <= RECORD_RESET;
        misc1_q[i]  <= RECORD_RESET;
      end
    end else if (wr_en) begin
      unique case (field)
        FIELD_STATUS: status_q[idx] <= merge(status_q[idx], hi_half, wr_data);
        FIELD_MISC0:  misc0_q[idx]  <= merge(misc0_q[idx], hi_half, wr_data);
        default:      misc1_q[idx]  <= merge(misc1_q[idx], hi_half, wr_data);
      endcase
    end
  end

endmodule

// >>> rtl/errwin_top.sv
// Selected error record window: decode, permission checks, record access
`timescale 1ns/10ps
module errwin_top
  import errwin_pkg::*;
#(
  parameter int NUM_RECORDS = 4,
  parameter int IDX_W       = 2
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic                REQ_VALID,
  input  wire logic                REQ_WRITE,
  input  wire logic [2:0]          REQ_OP1,
  input  wire logic [3:0]          REQ_CRN,
  input  wire logic [3:0]          REQ_CRM,
  input  wire logic [2:0]          REQ_OP2,
  input  wire logic [31:0]         REQ_WDATA,
  input  wire logic [1:0]          PRIV_LEVEL,
  input  wire logic                NONSECURE,
  input  wire logic                MONITOR_MODE,
  input  wire logic                ERR_EXT_PRESENT,
  input  wire logic                EL2_PRESENT,
  input  wire logic                EL2_IS_64,
  input  wire logic                EL3_PRESENT,
  input  wire logic                EL3_IS_64,
  input  wire logic                HYP_ERROR_TRAP_BIT,
  input  wire logic                HYP_CRN5_TRAP_BIT,
  input  wire logic                HYP32_ERROR_TRAP_BIT,
  input  wire logic                HYP32_CRN5_TRAP_BIT,
  input  wire logic                MONITOR_ERROR_TRAP_BIT,
  input  wire logic                MONITOR32_ERROR_TRAP_BIT,
  input  wire logic [IDX_W-1:0]    RECORD_SELECTOR,
  input  wire logic [IDX_W:0]      RECORD_COUNT,
  output logic                     RSP_VALID,
  output logic [31:0]              RSP_RDATA,
  output errwin_pkg::result_e      RSP_RESULT,
  output logic                     RSP_HIT
);

  import errwin_pkg::*;

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       rst_n_i;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n_i = rst_sync_q;

  // Encoding decode
  logic   is_m0_lo;
  logic   is_m0_hi;
  logic   is_m1_lo;
  logic   is_m1_hi;
  logic   is_st_lo;
  logic   hit;
  logic   hi_half;
  field_e field;

  assign is_m0_lo = REQ_OP1 == OP1_WIN && REQ_CRN == CRN_WIN &&
                    REQ_CRM == CRM_MISC && REQ_OP2 == OP2_M0_LO; // RULE1
  assign is_m0_hi = REQ_OP1 == OP1_WIN && REQ_CRN == CRN_WIN &&
                    REQ_CRM == CRM_MISC && REQ_OP2 == OP2_M0_HI; // RULE2
  assign is_m1_lo = REQ_OP1 == OP1_WIN && REQ_CRN == CRN_WIN &&
                    REQ_CRM == CRM_MISC && REQ_OP2 == OP2_M1_LO; // RULE3
  assign is_m1_hi = REQ_OP1 == OP1_WIN && REQ_CRN == CRN_WIN &&
                    REQ_CRM == CRM_MISC && REQ_OP2 == OP2_M1_HI; // RULE4
  assign is_st_lo = REQ_OP1 == OP1_WIN && REQ_CRN == CRN_WIN &&
                    REQ_CRM == CRM_STATUS && REQ_OP2 == OP2_ST_LO; // RULE5
  assign hit      = is_m0_lo | is_m0_hi | is_m1_lo | is_m1_hi | is_st_lo;
  assign hi_half  = is_m0_hi | is_m1_hi;
  assign field    = is_st_lo ? FIELD_STATUS :
                    (is_m0_lo | is_m0_hi) ? FIELD_MISC0 : FIELD_MISC1;

  // Permission checks; no security input reaches the decode
  logic at_el0;
  logic ns_el1;
  logic undef_c;
  logic trap_el2_64;
  logic trap_el2_32;
  logic trap_el3_64;
  logic trap_el3_32;
  logic in_range;

  assign at_el0      = PRIV_LEVEL == 2'h0;
  assign ns_el1      = NONSECURE && PRIV_LEVEL == 2'h1;
  assign undef_c     = !ERR_EXT_PRESENT || at_el0; // RULE6 RULE16
  assign trap_el2_64 = EL2_PRESENT && EL2_IS_64 && ns_el1 &&
                       (HYP_ERROR_TRAP_BIT || HYP_CRN5_TRAP_BIT); // RULE8 RULE9
  assign trap_el2_32 = EL2_PRESENT && !EL2_IS_64 && ns_el1 &&
                       (HYP32_ERROR_TRAP_BIT ||
                        HYP32_CRN5_TRAP_BIT); // RULE10 RULE11
  assign trap_el3_64 = EL3_PRESENT && EL3_IS_64 && MONITOR_ERROR_TRAP_BIT &&
                       (PRIV_LEVEL == 2'h1 || PRIV_LEVEL == 2'h2); // RULE12
  assign trap_el3_32 = EL3_PRESENT && !EL3_IS_64 && MONITOR32_ERROR_TRAP_BIT &&
                       !MONITOR_MODE && PRIV_LEVEL != 2'h3; // RULE13
  assign in_range    = {1'b0, RECORD_SELECTOR} < RECORD_COUNT; // RULE7

  result_e result_c;

  // Undefined first, then level 2 traps, then level 3 traps
  assign result_c = undef_c     ? RES_UNDEF    :
                    trap_el2_64 ? RES_TRAP_EL2 :
                    trap_el2_32 ? RES_HYP_TRAP :
                    trap_el3_64 ? RES_TRAP_EL3 :
                    trap_el3_32 ? RES_MON_TRAP : RES_OK; // RULE14

  logic        do_access;
  logic        wr_en;
  logic [31:0] store_rdata;
  logic [31:0] rdata_d;

  assign do_access = REQ_VALID && hit && result_c == RES_OK;
  assign wr_en     = do_access && REQ_WRITE && in_range; // RULE7 RULE15
  assign rdata_d   = (do_access && !REQ_WRITE && in_range) ? store_rdata
                                                           : 32'h0; // RULE7

  errwin_record_store #(
    .NUM_RECORDS (NUM_RECORDS),
    .IDX_W       (IDX_W)
  ) u_store (
    .clk     (CLK),
    .rst_n   (rst_n_i),
    .idx     (RECORD_SELECTOR),
    .field   (field),
    .hi_half (hi_half),
    .wr_en   (wr_en),
    .wr_data (REQ_WDATA),
    .rd_data (store_rdata)
  );

  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      RSP_VALID  <= 1'b0;
      RSP_RDATA  <= 32'h0;
      RSP_RESULT <= RES_OK;
      RSP_HIT    <= 1'b0;
    end else begin
      RSP_VALID  <= REQ_VALID;
      RSP_RDATA  <= rdata_d;
      RSP_RESULT <= (REQ_VALID && hit) ? result_c : RES_OK;
      RSP_HIT    <= REQ_VALID && hit;
    end
  end

  // Assertions
  a_el0_undef_resp: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && PRIV_LEVEL == 2'h0 |=> RSP_RESULT == RES_UNDEF) // RULE6
    else $error("level 0 access not undefined");

  a_noext_undef: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && !ERR_EXT_PRESENT |=> RSP_RESULT == RES_UNDEF) // RULE16
    else $error("missing extension access not undefined");

  a_range_reads_zero: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && !in_range |=> RSP_RDATA == 32'h0) // RULE7
    else $error("out of range read not zero");

  a_el2_trap_64: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && ERR_EXT_PRESENT && EL2_PRESENT && EL2_IS_64 &&
    ns_el1 && (HYP_ERROR_TRAP_BIT || HYP_CRN5_TRAP_BIT)
    |=> RSP_RESULT == RES_TRAP_EL2) // RULE8 RULE9
    else $error("level 2 trap missed");

  a_el2_trap_32: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && ERR_EXT_PRESENT && EL2_PRESENT && !EL2_IS_64 &&
    ns_el1 && (HYP32_ERROR_TRAP_BIT || HYP32_CRN5_TRAP_BIT)
    |=> RSP_RESULT == RES_HYP_TRAP) // RULE10 RULE11
    else $error("hyp trap missed");

  a_el3_trap_64: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && ERR_EXT_PRESENT && !trap_el2_64 && !trap_el2_32 &&
    EL3_PRESENT && EL3_IS_64 && MONITOR_ERROR_TRAP_BIT &&
    PRIV_LEVEL == 2'h2 |=> RSP_RESULT == RES_TRAP_EL3) // RULE12
    else $error("level 3 trap missed");

  a_el3_trap_32: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && ERR_EXT_PRESENT && PRIV_LEVEL == 2'h3 &&
    !EL3_IS_64 |=> RSP_RESULT == RES_OK) // RULE13
    else $error("highest level access wrongly trapped");

  sequence s_write_lo;
    REQ_VALID && REQ_WRITE && is_m0_lo && result_c == RES_OK && in_range;
  endsequence
  sequence s_read_lo_same;
    REQ_VALID && !REQ_WRITE && is_m0_lo && result_c == RES_OK && in_range &&
    RECORD_SELECTOR == $past(RECORD_SELECTOR);
  endsequence

  a_write_read_back: assert property (@(posedge CLK) disable iff (!rst_n_i)
    s_write_lo ##1 s_read_lo_same |=> RSP_RDATA == $past(REQ_WDATA, 2)) // RULE1 RULE18
    else $error("misc low half not read back");

  a_fault_zero_data: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && result_c != RES_OK |=> RSP_RDATA == 32'h0) // RULE14
    else $error("faulted access returned data");

  a_hit_follows: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && !hit |=> !RSP_HIT && RSP_RESULT == RES_OK) // RULE5
    else $error("non-window access reported as window");

  a_trap_priority: assert property (@(posedge CLK) disable iff (!rst_n_i)
    REQ_VALID && hit && undef_c && trap_el2_64 |=> RSP_RESULT == RES_UNDEF) // RULE14
    else $error("priority order broken");

endmodule
